// file: verilog/fpm_consts.svh
// Constants for the fixed-point multiply/accumulate datapath.
// Assumes a 32-bit APB register window with byte addresses below 8'h28.
`ifndef FPM_CONSTS_SVH
`define FPM_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define FPM_OFS_CTRL      8'h00
`define FPM_OFS_OPX       8'h04
`define FPM_OFS_OPY       8'h08
`define FPM_OFS_CMD       8'h0C
`define FPM_OFS_ACCUMULATOR_A_LO   8'h10
`define FPM_OFS_ACCUMULATOR_A_HI   8'h14
`define FPM_OFS_ACCUMULATOR_B_LO   8'h18
`define FPM_OFS_ACCUMULATOR_B_HI   8'h1C
`define FPM_OFS_WBDATA    8'h20
`define FPM_OFS_STATUS    8'h24

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FPM_CTRL_INT_BIT    0
`define FPM_CTRL_UNSG_BIT   1
`define FPM_CTRL_CONV_BIT   2
`define FPM_CTRL_SAT_A_BIT  3
`define FPM_CTRL_SAT_B_BIT  4
`define FPM_CTRL_SATW_BIT   5
`define FPM_CTRL_WIDE_BIT   6
`define FPM_CTRL_W          7
`define FPM_CMD_OP_HI       3
`define FPM_CMD_OP_LO       0
`define FPM_CMD_TGT_BIT     4
`define FPM_CMD_WB_BIT      5
`define FPM_STAT_W          3

// ----------------------------------------
// Reset values and saturation limits
// ----------------------------------------
`define FPM_CTRL_RST      7'h00
`define FPM_ACC_RST       40'h0000000000
`define FPM_ROUND_HALF    40'h0000008000
`define FPM_MAX_NARROW    40'h007FFFFFFF
`define FPM_MIN_NARROW    40'hFF80000000
`define FPM_MAX_WIDE      40'h7FFFFFFFFF
`define FPM_MIN_WIDE      40'h8000000000
`define FPM_WORD_MAX      16'h7FFF
`define FPM_WORD_MIN      16'h8000

`endif

// file: verilog/fpm_pkg.sv
// Types shared by the multiply/accumulate datapath modules.
// Assumes nothing of its surroundings.
package fpm_pkg;
	// Operation codes, in order from 0
	typedef enum logic [3:0] {
		FPM_OP_CLEAR,
		FPM_OP_DSQ,
		FPM_OP_DSQ_ACC,
		FPM_OP_MUL_ACC,
		FPM_OP_MUL_SUB,
		FPM_OP_MUL,
		FPM_OP_MUL_NEG,
		FPM_OP_PREFETCH,
		FPM_OP_ACC_ADD,
		FPM_OP_ACC_SUB,
		FPM_OP_ACC_NEG
	} fpm_op_t;
	typedef logic [39:0] fpm_acc_t;
endpackage : fpm_pkg

// file: verilog/fpm_mul_if.sv
// Interface between the datapath control and its multiplier.
// Assumes a purely combinational multiplier on the far side.
`timescale 1ns/1ps
`default_nettype none
interface fpm_mul_if;
	logic signed [16:0] op_a;
	logic signed [16:0] op_b;
	logic               frac_mode;
	logic        [39:0] product;
	modport client (output op_a, output op_b, output frac_mode, input product);
	modport unit   (input op_a, input op_b, input frac_mode, output product);
endinterface : fpm_mul_if
`default_nettype wire

// file: verilog/fpm_mul.sv
// 17x17 signed multiplier with fractional alignment shift.
// Assumes operands already extended to 17 bits by the caller.
`timescale 1ns/1ps
`default_nettype none
module fpm_mul
	import fpm_pkg::*;
(
	fpm_mul_if.unit mul
);
	logic signed [33:0] raw;
	logic        [39:0] ext;

	// ----------------------------------------
	// Product and alignment
	// ----------------------------------------
	// Full-width product, so no operand pair can overflow it
	assign raw = mul.op_a * mul.op_b;
	assign ext = {{6{raw[33]}}, raw};
	// Shifter: fractional format drops the duplicated sign bit
	assign mul.product = mul.frac_mode ? {ext[38:0], 1'b0} : ext;
endmodule : fpm_mul
`default_nettype wire

// file: verilog/fpm_mac_dp.sv
// Fixed-point multiply/accumulate datapath with APB register access.
// Assumes one APB master on pclk; one operation per command write.
// Function
// - 17x17 multiplier, shifter, 40-bit adder, two accumulators
// - One datapath operation per command, never overlapped
// - Accumulator add, subtract, negate need no operands
// - Select fractional or integer multiply
// - Select signed or unsigned multiply
// - Select conventional or convergent rounding
// - Separate saturation enables per accumulator
// - Saturation enable for stored words
// - Select normal or wide saturation limit
// - Difference square loads target, no write-back
// - Multiply accumulate adds product, allows write-back
// - Multiply subtract removes product, allows write-back
// - Multiply loads product, no write-back
// - Negated multiply loads minus product, no write-back
// - Prefetch keeps target, allows write-back
`timescale 1ns/1ps
`default_nettype none
`include "fpm_consts.svh"
module fpm_mac_dp
	import fpm_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [15:0] mem_wr_data,
	output logic             mem_wr_strobe
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [`FPM_CTRL_W-1:0] ctrl_reg;
	logic [15:0]            x_reg;
	logic [15:0]            y_reg;
	fpm_acc_t               acc_a_reg;
	fpm_acc_t               acc_b_reg;
	fpm_acc_t               acc_a_next;
	fpm_acc_t               acc_b_next;
	logic [15:0]            wb_data_reg;
	logic [`FPM_STAT_W-1:0] status_reg;
	logic                   setup;
	logic                   wr_fire;
	logic                   cmd_fire;
	fpm_op_t                cmd_op;
	logic                   cmd_tgt;
	logic                   cmd_wb;
	logic                   addr_ok;
	logic [31:0]            rd_mux;
	logic signed [16:0]     diff;
	logic signed [16:0]     opx;
	logic signed [16:0]     opy;
	logic                   dsq;
	fpm_acc_t               acc_t;
	fpm_acc_t               acc_o;
	logic [40:0]            sum;
	logic                   acc_wr;
	logic [40:0]            sat_out;
	logic                   round_up;
	fpm_acc_t               rounded;
	logic                   word_ovf;
	logic [15:0]            store_word;
	logic                   wb_ok;
	logic                   int_mode;
	logic                   unsg_mode;
	logic                   conv_mode;
	logic                   wide_mode;
	logic                   sat_t_en;
	logic                   sat_w_en;

	fpm_mul_if mul ();

	fpm_mul u_mul (
		.mul (mul.unit)
	);

	// Saturate a 41-bit sum; top bit of the result flags an overflow
	function automatic logic [40:0] fpm_sat(input logic [40:0] s, input logic en,
		input logic wide);
		logic big;
		logic lost;
		big  = wide ? (s[40] != s[39]) : ~((&s[40:31]) | ~(|s[40:31]));
		lost = s[40] != s[39];
		if (en && big) begin
			if (s[40]) begin
				fpm_sat = {1'b1, wide ? `FPM_MIN_WIDE : `FPM_MIN_NARROW};
			end else begin
				fpm_sat = {1'b1, wide ? `FPM_MAX_WIDE : `FPM_MAX_NARROW};
			end
		end else begin
			fpm_sat = {(~en) & lost, s[39:0]};
		end
	endfunction : fpm_sat

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Bus strobes and command fields
	assign setup    = psel & ~penable;
	assign wr_fire  = psel & penable & pready & pwrite;
	assign cmd_fire = wr_fire && (paddr == `FPM_OFS_CMD);
	assign cmd_op   = fpm_op_t'(pwdata[`FPM_CMD_OP_HI:`FPM_CMD_OP_LO]);
	assign cmd_tgt  = pwdata[`FPM_CMD_TGT_BIT];
	assign cmd_wb   = pwdata[`FPM_CMD_WB_BIT];

	// Address decode and read data
	always_comb begin
		addr_ok = 1'b1;
		rd_mux  = 32'h00000000;
		case (paddr)
			`FPM_OFS_CTRL:    rd_mux = {25'h0000000, ctrl_reg};
			`FPM_OFS_OPX:     rd_mux = {16'h0000, x_reg};
			`FPM_OFS_OPY:     rd_mux = {16'h0000, y_reg};
			`FPM_OFS_CMD:     rd_mux = 32'h00000000;
			`FPM_OFS_ACCUMULATOR_A_LO: rd_mux = acc_a_reg[31:0];
			`FPM_OFS_ACCUMULATOR_A_HI: rd_mux = {24'h000000, acc_a_reg[39:32]};
			`FPM_OFS_ACCUMULATOR_B_LO: rd_mux = acc_b_reg[31:0];
			`FPM_OFS_ACCUMULATOR_B_HI: rd_mux = {24'h000000, acc_b_reg[39:32]};
			`FPM_OFS_WBDATA:  rd_mux = {16'h0000, wb_data_reg};
			`FPM_OFS_STATUS:  rd_mux = {29'h00000000, status_reg};
			default:          addr_ok = 1'b0;
		endcase
	end

	// One wait-free access phase; answer prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= setup;
			pslverr <= setup & ~addr_ok;
			prdata  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// Configuration and operand registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `FPM_CTRL_RST;
			x_reg    <= 16'h0000;
			y_reg    <= 16'h0000;
		end else if (wr_fire) begin
			if (paddr == `FPM_OFS_CTRL) begin
				ctrl_reg <= pwdata[`FPM_CTRL_W-1:0];
			end
			if (paddr == `FPM_OFS_OPX) begin
				x_reg <= pwdata[15:0];
			end
			if (paddr == `FPM_OFS_OPY) begin
				y_reg <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------
	// Mode bits
	// ----------------------------------------
	// fractional or integer
	assign int_mode  = ctrl_reg[`FPM_CTRL_INT_BIT];
	assign unsg_mode = ctrl_reg[`FPM_CTRL_UNSG_BIT];
	assign conv_mode = ctrl_reg[`FPM_CTRL_CONV_BIT];
	assign wide_mode = ctrl_reg[`FPM_CTRL_WIDE_BIT];
	assign sat_t_en  = cmd_tgt ? ctrl_reg[`FPM_CTRL_SAT_B_BIT] : ctrl_reg[`FPM_CTRL_SAT_A_BIT];
	assign sat_w_en  = ctrl_reg[`FPM_CTRL_SATW_BIT];

	// ----------------------------------------
	// Multiplier operands
	// ----------------------------------------
	// difference formed by its own subtracter ahead of the multiplier, always signed
	assign diff = {x_reg[15], x_reg} - {y_reg[15], y_reg};
	assign dsq  = (cmd_op == FPM_OP_DSQ) || (cmd_op == FPM_OP_DSQ_ACC);
	assign opx  = unsg_mode ? {1'b0, x_reg} : {x_reg[15], x_reg};
	assign opy  = unsg_mode ? {1'b0, y_reg} : {y_reg[15], y_reg};
	// one shared multiplier for all product forms
	assign mul.op_a      = dsq ? diff : opx;
	assign mul.op_b      = dsq ? diff : opy;
	assign mul.frac_mode = ~int_mode;

	// ----------------------------------------
	// Adder/subtracter
	// ----------------------------------------
	assign acc_t = cmd_tgt ? acc_b_reg : acc_a_reg;
	assign acc_o = cmd_tgt ? acc_a_reg : acc_b_reg;

	// Sum one bit wider than the accumulator, for overflow detection
	always_comb begin
		sum    = {acc_t[39], acc_t};
		acc_wr = 1'b1;
		case (cmd_op)
			FPM_OP_CLEAR:    sum = 41'h00000000000;
			FPM_OP_DSQ:      sum = {mul.product[39], mul.product};
			FPM_OP_DSQ_ACC:  sum = {acc_t[39], acc_t} + {mul.product[39], mul.product};
			FPM_OP_MUL_ACC:  sum = {acc_t[39], acc_t} + {mul.product[39], mul.product};
			FPM_OP_MUL_SUB:  sum = {acc_t[39], acc_t} - {mul.product[39], mul.product};
			FPM_OP_MUL:      sum = {mul.product[39], mul.product};
			FPM_OP_MUL_NEG:  sum = 41'h00000000000 - {mul.product[39], mul.product};
			FPM_OP_PREFETCH: acc_wr = 1'b0;
			FPM_OP_ACC_ADD:  sum = {acc_a_reg[39], acc_a_reg} + {acc_b_reg[39], acc_b_reg};
			FPM_OP_ACC_SUB:  sum = {acc_t[39], acc_t} - {acc_o[39], acc_o};
			FPM_OP_ACC_NEG:  sum = 41'h00000000000 - {acc_t[39], acc_t};
			default:         acc_wr = 1'b0;
		endcase
	end

	assign sat_out = fpm_sat(sum, sat_t_en, wide_mode);

	// Next accumulator values; only the target moves
	always_comb begin
		acc_a_next = acc_a_reg;
		acc_b_next = acc_b_reg;
		if (cmd_fire && acc_wr) begin
			if (cmd_tgt) begin
				acc_b_next = sat_out[39:0];
			end else begin
				acc_a_next = sat_out[39:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_a_reg <= `FPM_ACC_RST;
			acc_b_reg <= `FPM_ACC_RST;
		end else begin
			acc_a_reg <= acc_a_next;
			acc_b_reg <= acc_b_next;
		end
	end

	// ----------------------------------------
	// Write-back path
	// ----------------------------------------
	// convergent mode leaves an exact even half alone
	assign round_up = conv_mode | ~((acc_o[15:0] == 16'h8000) & ~acc_o[16]);
	assign rounded  = acc_o + (round_up ? `FPM_ROUND_HALF : `FPM_ACC_RST);
	assign word_ovf = ~((&rounded[39:31]) | ~(|rounded[39:31]));
	// clamp the stored word when enabled
	assign store_word = (sat_w_en && word_ovf) ?
		(rounded[39] ? `FPM_WORD_MIN : `FPM_WORD_MAX) : rounded[31:16];
	// only forms that offer write-back may store
	assign wb_ok = cmd_fire & cmd_wb & ((cmd_op == FPM_OP_CLEAR) |
		(cmd_op == FPM_OP_MUL_ACC) | (cmd_op == FPM_OP_MUL_SUB) |
		(cmd_op == FPM_OP_PREFETCH));

	// store pre-instruction value of the other accumulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_wr_strobe <= 1'b0;
			mem_wr_data   <= 16'h0000;
			wb_data_reg   <= 16'h0000;
		end else begin
			mem_wr_strobe <= wb_ok;
			if (wb_ok) begin
				mem_wr_data <= store_word;
				wb_data_reg <= store_word;
			end
		end
	end

	// Sticky overflow flags, write one to clear; a new event wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= 3'h0;
		end else begin
			status_reg <= (status_reg & ~((wr_fire && paddr == `FPM_OFS_STATUS) ?
				pwdata[2:0] : 3'h0)) | {wb_ok & word_ovf,
				cmd_fire & acc_wr & cmd_tgt & sat_out[40],
				cmd_fire & acc_wr & ~cmd_tgt & sat_out[40]};
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	logic signed [31:0] chk_ps;
	logic [31:0]        chk_pu;
	logic [31:0]        chk_rc;
	logic               chk_a_in;
	logic               chk_plain;

	// Independent reference values for the checks
	assign chk_ps    = $signed(x_reg) * $signed(y_reg);
	assign chk_pu    = x_reg * y_reg;
	assign chk_rc    = acc_b_reg[31:0] + 32'h00008000;
	assign chk_a_in  = (&acc_a_reg[39:31]) | ~(|acc_a_reg[39:31]);
	assign chk_plain = int_mode & ~ctrl_reg[`FPM_CTRL_SAT_A_BIT];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_issue_a(fpm_op_t op);
		cmd_fire && (cmd_op == op) && !cmd_tgt;
	endsequence

	a_bus_ready: assert property (setup |=> pready ##1 !pready || setup)
		else $error("pready not one cycle after setup");
	a_other_kept: assert property (s_issue_a(FPM_OP_MUL_ACC) |=> $stable(acc_b_reg))
		else $error("non-target accumulator changed");
	a_mul_signed: assert property (s_issue_a(FPM_OP_MUL) and (chk_plain && !unsg_mode)
		|=> acc_a_reg == {{8{$past(chk_ps[31])}}, $past(chk_ps)})
		else $error("signed integer product wrong");
	a_mul_unsigned: assert property (s_issue_a(FPM_OP_MUL) and (chk_plain && unsg_mode)
		|=> acc_a_reg == {8'h00, $past(chk_pu)})
		else $error("unsigned integer product wrong");
	a_mul_frac: assert property (s_issue_a(FPM_OP_MUL) and (!int_mode && !unsg_mode
		&& !ctrl_reg[`FPM_CTRL_SAT_A_BIT])
		|=> acc_a_reg == {{7{$past(chk_ps[31])}}, $past(chk_ps), 1'b0})
		else $error("fractional product not aligned");
	a_mul_neg: assert property (s_issue_a(FPM_OP_MUL_NEG) and (chk_plain && !unsg_mode)
		|=> acc_a_reg == 40'h0 - {{8{$past(chk_ps[31])}}, $past(chk_ps)})
		else $error("negated product wrong");
	a_acc_neg: assert property (s_issue_a(FPM_OP_ACC_NEG) and !ctrl_reg[`FPM_CTRL_SAT_A_BIT]
		|=> acc_a_reg == 40'h0 - $past(acc_a_reg))
		else $error("accumulator negate wrong");
	a_clear_zero: assert property (s_issue_a(FPM_OP_CLEAR) |=> acc_a_reg == 40'h0)
		else $error("clear left accumulator nonzero");
	a_prefetch_hold: assert property (s_issue_a(FPM_OP_PREFETCH) |=> $stable(acc_a_reg))
		else $error("prefetch changed target");
	a_dsq_no_store: assert property (cmd_fire && dsq && cmd_wb |=> !mem_wr_strobe)
		else $error("difference square stored a word");
	a_wb_store: assert property (cmd_fire && cmd_wb && (cmd_op == FPM_OP_MUL_ACC ||
		cmd_op == FPM_OP_MUL_SUB) |=> mem_wr_strobe ##1 !mem_wr_strobe)
		else $error("allowed write-back missing");
	a_wb_round: assert property (wb_ok && !cmd_tgt && conv_mode && !sat_w_en
		|=> mem_wr_data == $past(chk_rc[31:16]))
		else $error("conventional rounding wrong");
	a_store_clamp: assert property (wb_ok && !cmd_tgt && sat_w_en &&
		acc_b_reg[39:38] == 2'h0 && (|acc_b_reg[37:31]) |=> mem_wr_data == 16'h7FFF)
		else $error("stored word not saturated");
	a_sat_bound: assert property (cmd_fire && !cmd_tgt && ctrl_reg[`FPM_CTRL_SAT_A_BIT]
		&& !wide_mode && chk_a_in |=> chk_a_in)
		else $error("accumulator a left normal range");
endmodule : fpm_mac_dp
`default_nettype wire

// file: verif/fpm_mem_model.sv
// Data memory model that takes the words the datapath stores.
// Assumes a registered one-cycle store strobe on pclk.
`timescale 1ns/1ps
`default_nettype none
module fpm_mem_model (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [15:0] mem_wr_data,
	input  wire logic        mem_wr_strobe,
	output int               store_count,
	output logic      [15:0] last_word
);
	// Count every strobe; a held strobe would show as extra stores
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_count <= 0;
			last_word   <= 16'h0000;
		end else if (mem_wr_strobe) begin
			store_count <= store_count + 1;
			last_word   <= mem_wr_data;
		end
	end
endmodule : fpm_mem_model
`default_nettype wire

// file: verif/fpm_mac_dp_tb.sv
// Self-checking bench for the multiply/accumulate datapath.
// Assumes the register map and command fields of the constants header.
`timescale 1ns/1ps
`default_nettype none
`include "fpm_consts.svh"
module fpm_mac_dp_tb
	import fpm_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] mem_wr_data;
	logic        mem_wr_strobe;
	logic [15:0] last_word;
	int          store_count;
	int          fail_count = 0;
	int          total_checks = 0;
	int          cycles = 0;

	// 125 MHz
	always #4 pclk = ~pclk;

	fpm_mac_dp u_fpm_mac_dp (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .mem_wr_data(mem_wr_data),
		.mem_wr_strobe(mem_wr_strobe));
	fpm_mem_model u_fpm_mem_model (.pclk(pclk), .presetn(presetn), .mem_wr_data(mem_wr_data),
		.mem_wr_strobe(mem_wr_strobe), .store_count(store_count), .last_word(last_word));

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : test_done

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		total_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One APB transfer; an idle edge after it keeps drives one per step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// Wait for the answer; only the bench timeout ends a hang
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
		chk({39'h0, e}, 40'h0);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		chk({8'h0, q}, {8'h0, exp});
	endtask : rd

	task automatic acc(input logic t, input logic [39:0] e);
		logic [7:0] a;
		a = t ? `FPM_OFS_ACCUMULATOR_B_LO : `FPM_OFS_ACCUMULATOR_A_LO;
		rd(a, e[31:0]);
		rd(a + 8'h04, {24'h0, e[39:32]});
	endtask : acc

	task automatic xy(input logic [15:0] x, input logic [15:0] y);
		wr(`FPM_OFS_OPX, {16'h0, x});
		wr(`FPM_OFS_OPY, {16'h0, y});
	endtask : xy

	// Issue a command and count the stores that follow it
	task automatic op(input logic [3:0] o, input logic t, input logic wb, input int ns);
		int n0;
		n0 = store_count;
		wr(`FPM_OFS_CMD, {26'h0, wb, t, o});
		@(posedge pclk);
		chk(40'(store_count - n0), 40'(ns));
	endtask : op

	task automatic word(input logic [15:0] e);
		chk({24'h0, last_word}, {24'h0, e});
	endtask : word

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic test_reset();
		logic [31:0] q;
		logic        e;
		rd(`FPM_OFS_CTRL, 32'h0);
		acc(1'b0, 40'h0);
		rd(`FPM_OFS_STATUS, 32'h0);
		// Unmapped place refuses reads and writes
		apb(1'b0, 8'h28, 32'h0, q, e);
		chk({7'h0, e, q}, {7'h0, 1'b1, 32'h0});
		apb(1'b1, 8'h28, 32'hFFFFFFFF, q, e);
		chk({39'h0, e}, 40'h1);
		op(4'hB, 1'b0, 1'b1, 0);
		acc(1'b0, 40'h0);
		$display("reset test finished");
	endtask : test_reset

	task automatic test_mul();
		wr(`FPM_OFS_CTRL, 32'h01);
		xy(16'h0003, 16'h0005);
		op(FPM_OP_MUL, 1'b0, 1'b1, 0);
		acc(1'b0, 40'h0F);
		op(FPM_OP_MUL_ACC, 1'b0, 1'b1, 1);
		acc(1'b0, 40'h1E);
		op(FPM_OP_MUL_SUB, 1'b0, 1'b1, 1);
		acc(1'b0, 40'h0F);
		op(FPM_OP_MUL_NEG, 1'b1, 1'b1, 0);
		acc(1'b1, 40'hFFFFFFFFF1);
		op(FPM_OP_MUL_NEG, 1'b0, 1'b1, 0);
		acc(1'b0, 40'hFFFFFFFFF1);
		// Fractional mode doubles the product
		wr(`FPM_OFS_CTRL, 32'h00);
		op(FPM_OP_MUL, 1'b0, 1'b0, 0);
		acc(1'b0, 40'h1E);
		wr(`FPM_OFS_CTRL, 32'h03);
		xy(16'hFFFF, 16'h0002);
		op(FPM_OP_MUL, 1'b0, 1'b0, 0);
		acc(1'b0, 40'h1FFFE);
		wr(`FPM_OFS_CTRL, 32'h01);
		op(FPM_OP_MUL, 1'b0, 1'b0, 0);
		acc(1'b0, 40'hFFFFFFFFFE);
		$display("multiply test finished");
	endtask : test_mul

	task automatic test_dsq_accops();
		xy(16'h0007, 16'h0002);
		op(FPM_OP_DSQ, 1'b0, 1'b1, 0);
		acc(1'b0, 40'h19);
		op(FPM_OP_DSQ_ACC, 1'b0, 1'b1, 0);
		acc(1'b0, 40'h32);
		xy(16'h0003, 16'h0005);
		op(FPM_OP_MUL, 1'b1, 1'b0, 0);
		op(FPM_OP_ACC_ADD, 1'b0, 1'b0, 0);
		acc(1'b0, 40'h41);
		op(FPM_OP_ACC_SUB, 1'b0, 1'b0, 0);
		acc(1'b0, 40'h32);
		op(FPM_OP_ACC_NEG, 1'b0, 1'b0, 0);
		acc(1'b0, 40'hFFFFFFFFCE);
		acc(1'b1, 40'h0F);
		$display("difference and accumulator test finished");
	endtask : test_dsq_accops

	task automatic test_round();
		xy(16'h4000, 16'h0002);
		op(FPM_OP_MUL, 1'b1, 1'b0, 0);
		op(FPM_OP_CLEAR, 1'b0, 1'b1, 1);
		acc(1'b0, 40'h0);
		word(16'h0000);
		wr(`FPM_OFS_CTRL, 32'h05);
		op(FPM_OP_CLEAR, 1'b0, 1'b1, 1);
		word(16'h0001);
		// Convergent rounds up when the kept word is odd
		wr(`FPM_OFS_CTRL, 32'h01);
		xy(16'h4000, 16'h0006);
		op(FPM_OP_MUL, 1'b1, 1'b0, 0);
		op(FPM_OP_CLEAR, 1'b0, 1'b1, 1);
		word(16'h0002);
		$display("rounding test finished");
	endtask : test_round

	task automatic test_sat();
		wr(`FPM_OFS_CTRL, 32'h09);
		xy(16'h8000, 16'h8000);
		op(FPM_OP_CLEAR, 1'b0, 1'b0, 0);
		op(FPM_OP_MUL_ACC, 1'b0, 1'b0, 0);
		op(FPM_OP_MUL_ACC, 1'b0, 1'b0, 0);
		acc(1'b0, 40'h007FFFFFFF);
		op(FPM_OP_CLEAR, 1'b1, 1'b0, 0);
		op(FPM_OP_MUL_ACC, 1'b1, 1'b0, 0);
		op(FPM_OP_MUL_ACC, 1'b1, 1'b0, 0);
		acc(1'b1, 40'h0080000000);
		wr(`FPM_OFS_CTRL, 32'h49);
		op(FPM_OP_CLEAR, 1'b0, 1'b0, 0);
		op(FPM_OP_MUL_ACC, 1'b0, 1'b0, 0);
		op(FPM_OP_MUL_ACC, 1'b0, 1'b0, 0);
		acc(1'b0, 40'h0080000000);
		// Stored word of B clamps only with store saturation on
		wr(`FPM_OFS_CTRL, 32'h21);
		op(FPM_OP_PREFETCH, 1'b0, 1'b1, 1);
		word(16'h7FFF);
		acc(1'b0, 40'h0080000000);
		wr(`FPM_OFS_CTRL, 32'h01);
		op(FPM_OP_PREFETCH, 1'b0, 1'b1, 1);
		word(16'h8000);
		rd(`FPM_OFS_WBDATA, 32'h00008000);
		// A clamp and two stored-word overflows left their flags
		rd(`FPM_OFS_STATUS, 32'h00000005);
		wr(`FPM_OFS_STATUS, 32'h00000007);
		rd(`FPM_OFS_STATUS, 32'h00000000);
		$display("saturation test finished");
	endtask : test_sat

	// ----------------------------------------
	// Main sequence and hang guard
	// ----------------------------------------
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 3000) begin
			fail_count++;
			test_done();
		end
	end

	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		test_reset();
		test_mul();
		test_dsq_accops();
		test_round();
		test_sat();
		test_done();
	end
endmodule : fpm_mac_dp_tb
`default_nettype wire
